// ===== design/reset_ctrl_regs.vh
/*
  Constants for the reset-source and watchdog control block: register
  indices, field positions, reset values, command values and timing.
  Assumes a 100 MHz system clock and a 32-bit APB with word registers.
*/
`ifndef RESET_CTRL_REGS_VH
`define RESET_CTRL_REGS_VH

// Register indices; byte address is four times the index
`define RSRC_IDX            12'h0ef
`define WDOG_IDX            12'h0ff

// Reset-cause register fields
`define RSRC_CNV_BIT        6
`define RSRC_CMP_BIT        5
`define RSRC_SW_BIT         4
`define RSRC_WDT_BIT        3
`define RSRC_MCD_BIT        2
`define RSRC_POR_BIT        1
`define RSRC_PIN_BIT        0
`define RSRC_RESET          8'h00
`define FLAGS_POR_ONLY      7'h02

// Watchdog control fields and command values
`define WDOG_RUN_BIT        4
`define WDOG_KEEP_BIT       7
`define WDOG_INTERVAL_RESET 3'h7
`define WDOG_CMD_RELOAD     8'ha5
`define WDOG_CMD_DIS1       8'hde
`define WDOG_CMD_DIS2       8'had
`define WDOG_CMD_LOCK       8'hff
`define WDOG_DIS_WINDOW     3'h4
`define WDOG_EXP_BASE       5'h06

// Timing, in system clock cycles at 100 MHz: 220 us and 100 ms
`define RST_HOLD_CYCLES     4'hc
`define MCD_TIMEOUT_CYC     20'h055f0
`define POR_DELAY_CYC       24'h989680

`endif

// ===== design/watchdog_timer.v
/*
  Watchdog counter with reload, two-step disable, lock and interval select.
  Assumes writes arrive as single-cycle strobes and that the reset input
  is the synchronous system reset of the surrounding block.
*/
`timescale 1ns/1ns
`default_nettype none
`include "reset_ctrl_regs.vh"

module watchdog_timer (
    // Clock and system reset
    input  wire       clk,
    input  wire       reset_n,
    // Control register write
    input  wire       wr_stb,
    input  wire [7:0] wr_data,
    // State
    output reg        running_q,
    output reg  [2:0] interval_q,
    output reg        timeout_q
);

    reg        lock_q;
    reg        pend_q;
    reg  [2:0] win_q;
    reg [20:0] cnt_q;

    // Timeout length in clocks: 4^(3+sel) = 2^(6+2*sel)
    function [20:0] wd_limit;
        input [2:0] sel;
        begin
            wd_limit = 21'h000001 << (`WDOG_EXP_BASE + {1'b0, sel, 1'b0});
        end
    endfunction

    always @(posedge clk) begin
        if (!reset_n) begin
            running_q  <= 1'b1;
            cnt_q      <= 21'h000000;
            interval_q <= `WDOG_INTERVAL_RESET;
            lock_q     <= 1'b0;
            pend_q     <= 1'b0;
            win_q      <= 3'h0;
            timeout_q  <= 1'b0;
        end else begin
            timeout_q <= running_q && (cnt_q == wd_limit(interval_q) - 21'h000001);
            if (running_q)
                cnt_q <= (cnt_q == wd_limit(interval_q) - 21'h000001) ?
                         21'h000000 : cnt_q + 21'h000001;
            if (pend_q && !wr_stb) begin
                win_q <= win_q + 3'h1;
                if (win_q == `WDOG_DIS_WINDOW - 3'h1)
                    pend_q <= 1'b0;
            end
            if (wr_stb) begin
                pend_q <= 1'b0;
                case (wr_data)
                    `WDOG_CMD_RELOAD: begin
                        running_q <= 1'b1;
                        cnt_q     <= 21'h000000;
                    end
                    `WDOG_CMD_DIS1: begin
                        pend_q <= 1'b1;
                        win_q  <= 3'h0;
                    end
                    `WDOG_CMD_DIS2: begin
                        if (pend_q && !lock_q && win_q < `WDOG_DIS_WINDOW)
                            running_q <= 1'b0;
                    end
                    `WDOG_CMD_LOCK: begin
                        lock_q <= 1'b1;
                    end
                    default: begin
                        if (!wr_data[`WDOG_KEEP_BIT])
                            interval_q <= wr_data[2:0];
                    end
                endcase
            end
        end
    end

endmodule // watchdog_timer

`default_nettype wire

// ===== design/reset_source_and_watchdog_control.v
/*
  Reset-source and watchdog control with an APB register slave.
  Holds the system reset output, drives the open-drain reset pin and
  records the cause of the last reset. Assumes reset_n is the power-on
  reset and that pins and the system-clock activity toggle are async.
*/
// Design decision made here: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "reset_ctrl_regs.vh"

module reset_source_and_watchdog_control #(
    parameter [19:0] MCD_TIMEOUT_CYCLES = `MCD_TIMEOUT_CYC,
    parameter [23:0] POR_DELAY_CYCLES   = `POR_DELAY_CYC
) (
    // Clock and power-on reset
    input  wire        clk,
    input  wire        reset_n,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_q,
    output reg         pready_q,
    output reg         pslverr_q,
    // Open-drain reset pin
    input  wire        rst_pin_i,
    output reg         rst_pin_o_q,
    output reg         rst_pin_oe_n_q,
    // Reset sources
    input  wire        convert_start_input,
    input  wire        comparator_out,
    input  wire        supply_ok,
    input  wire        supply_monitor_enable_pin,
    input  wire        sysclk_alive,
    // System reset to the rest of the device
    output reg         sys_reset_n_q
);

    // Synchroniser bit positions
    localparam PIN = 0;
    localparam CNV = 1;
    localparam CMP = 2;
    localparam SOK = 3;
    localparam MON = 4;
    localparam ALV = 5;

    reg  [5:0] meta_q;
    reg  [5:0] sync_q;
    reg        alive_prev_q;

    reg  [6:0] flags_q;
    reg        cnv_en_q;
    reg        cmp_en_q;
    reg        mcd_en_q;
    reg        mon_sel_q;
    reg  [3:0] hold_q;
    reg [23:0] por_cnt_q;
    reg [19:0] mcd_cnt_q;

    wire       wd_running;
    wire [2:0] wd_interval;
    wire       wd_timeout;

    reg  [6:0] cause_d;
    reg        por_cause_d;
    reg        event_d;

    // Address match against a register index
    function addr_hit;
        input [11:0] a;
        input [11:0] idx;
        begin
            addr_hit = (a == {idx[9:0], 2'b00});
        end
    endfunction

    wire in_reset    = ~sys_reset_n_q;
    wire pin_driving = ~rst_pin_oe_n_q;
    wire wr_en       = psel & penable & pwrite & pready_q;
    wire wr_rsrc     = wr_en & addr_hit(paddr, `RSRC_IDX) & ~in_reset;
    wire wr_wdog     = wr_en & addr_hit(paddr, `WDOG_IDX) & ~in_reset;
    wire wd_reset_n  = reset_n & sys_reset_n_q;

    // Supply below threshold while the monitor is a selected source
    wire supply_fail = mon_sel_q & sync_q[MON] & ~sync_q[SOK];
    wire alive_edge  = sync_q[ALV] ^ alive_prev_q;

    wire [7:0] rsrc_rd = {1'b0, flags_q};
    wire [7:0] wdog_rd = {3'h0, wd_running, 1'b0, wd_interval};

    watchdog_timer u_watchdog (
        .clk        (clk),
        .reset_n    (wd_reset_n),
        .wr_stb     (wr_wdog),
        .wr_data    (pwdata[7:0]),
        .running_q  (wd_running),
        .interval_q (wd_interval),
        .timeout_q  (wd_timeout)
    );

    // Cause selection, highest priority first
    always @* begin
        cause_d     = 7'h00;
        por_cause_d = 1'b0;
        event_d     = 1'b1;
        if (supply_fail || (wr_rsrc && pwdata[`RSRC_PIN_BIT])) begin
            cause_d     = `FLAGS_POR_ONLY;
            por_cause_d = 1'b1;
        end else if (!sync_q[PIN]) begin
            cause_d[`RSRC_PIN_BIT] = 1'b1;
        end else if (wd_timeout) begin
            cause_d[`RSRC_WDT_BIT] = 1'b1;
        end else if (mcd_en_q && mcd_cnt_q == MCD_TIMEOUT_CYCLES) begin
            cause_d[`RSRC_MCD_BIT] = 1'b1;
        end else if (wr_rsrc && pwdata[`RSRC_SW_BIT]) begin
            cause_d[`RSRC_SW_BIT] = 1'b1;
        end else if (cmp_en_q && !sync_q[CMP]) begin
            cause_d[`RSRC_CMP_BIT] = 1'b1;
        end else if (cnv_en_q && !sync_q[CNV]) begin
            cause_d[`RSRC_CNV_BIT] = 1'b1;
        end else begin
            event_d = 1'b0;
        end
    end

    // Input synchronisers
    always @(posedge clk) begin
        if (!reset_n) begin
            meta_q       <= 6'h3f;
            sync_q       <= 6'h3f;
            alive_prev_q <= 1'b1;
        end else begin
            meta_q       <= {sysclk_alive, supply_monitor_enable_pin, supply_ok,
                             comparator_out, convert_start_input, rst_pin_i};
            sync_q       <= meta_q;
            alive_prev_q <= sync_q[ALV];
        end
    end

    // Missing-clock detector: clocks since the last system-clock activity
    always @(posedge clk) begin
        if (!reset_n || in_reset || !mcd_en_q || alive_edge)
            mcd_cnt_q <= 20'h00000;
        else if (mcd_cnt_q != MCD_TIMEOUT_CYCLES)
            mcd_cnt_q <= mcd_cnt_q + 20'h00001;
    end

    // Reset sequencing, cause flags and pin drive
    always @(posedge clk) begin
        if (!reset_n) begin
            sys_reset_n_q  <= 1'b0;
            rst_pin_oe_n_q <= 1'b0;
            rst_pin_o_q    <= 1'b0;
            por_cnt_q      <= 24'h000000;
            hold_q         <= 4'h0;
            flags_q        <= `FLAGS_POR_ONLY;
        end else begin
            rst_pin_o_q <= 1'b0;
            if (supply_fail) begin
                rst_pin_oe_n_q <= 1'b0;
                por_cnt_q      <= 24'h000000;
                sys_reset_n_q  <= 1'b0;
                hold_q         <= 4'h0;
                flags_q        <= `FLAGS_POR_ONLY;
            end else if (!in_reset) begin
                if (event_d) begin
                    sys_reset_n_q <= 1'b0;
                    hold_q        <= 4'h0;
                    flags_q       <= cause_d;
                    if (por_cause_d) begin
                        rst_pin_oe_n_q <= 1'b0;
                        por_cnt_q      <= 24'h000000;
                    end
                end
            end else if (pin_driving) begin
                if (por_cnt_q == POR_DELAY_CYCLES - 24'h000001)
                    rst_pin_oe_n_q <= 1'b1;
                else
                    por_cnt_q <= por_cnt_q + 24'h000001;
            end else if (!sync_q[PIN]) begin
                hold_q <= 4'h0;
            end else if (hold_q == `RST_HOLD_CYCLES - 4'h1) begin
                sys_reset_n_q <= 1'b1;
            end else begin
                hold_q <= hold_q + 4'h1;
            end
        end
    end

    // Reset-source enables, cleared by every system reset; the supply monitor select mon_sel_q is set to 1
    always @(posedge clk) begin
        if (!reset_n || in_reset) begin
            cnv_en_q  <= 1'b0;
            cmp_en_q  <= 1'b0;
            mcd_en_q  <= 1'b0;
            mon_sel_q <= 1'b1;
        end else if (wr_rsrc) begin
            cnv_en_q <= pwdata[`RSRC_CNV_BIT];
            cmp_en_q <= pwdata[`RSRC_CMP_BIT];
            mcd_en_q <= pwdata[`RSRC_MCD_BIT];
            if (sync_q[MON])
                mon_sel_q <= pwdata[`RSRC_POR_BIT];
        end
    end

    // APB slave: data captured in setup, ready in the access phase
    always @(posedge clk) begin
        if (!reset_n) begin
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel & ~penable;
            if (psel && !penable) begin
                if (addr_hit(paddr, `RSRC_IDX)) begin
                    prdata_q  <= {24'h000000, rsrc_rd};
                    pslverr_q <= 1'b0;
                end else if (addr_hit(paddr, `WDOG_IDX)) begin
                    prdata_q  <= {24'h000000, wdog_rd};
                    pslverr_q <= 1'b0;
                end else begin
                    prdata_q  <= 32'h00000000;
                    pslverr_q <= 1'b1;
                end
            end else if (!psel) begin
                pslverr_q <= 1'b0;
            end
        end
    end

endmodule // reset_source_and_watchdog_control

`default_nettype wire

// ===== sim/reset_source_and_watchdog_control_properties.sv
/* Concurrent checks on the ports of the reset-source and watchdog block.
   Assumes the bind below and one clock domain with reset_n. */
`timescale 1ns/1ns
`default_nettype none
module rst_ctrl_checker #(
    parameter [23:0] POR_DELAY_CYCLES = 24'h000028
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata_q,
    input wire logic        pready_q,
    input wire logic        pslverr_q,
    // Pin and system reset
    input wire logic        rst_pin_i,
    input wire logic        rst_pin_o_q,
    input wire logic        rst_pin_oe_n_q,
    input wire logic        sys_reset_n_q
);
    logic [5:0]  hi_q;
    logic [23:0] lo_q;

    // Runs of pin high and of pin driven low
    always_ff @(posedge clk) begin
        hi_q <= !rst_pin_i ? 6'h00 : (hi_q == 6'h3f ? hi_q : hi_q + 6'h01);
        lo_q <= (!reset_n || rst_pin_oe_n_q) ? 24'h000000 : lo_q + 24'h000001;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence flag_wr;
        psel && penable && pready_q && pwrite && paddr == 12'h3bc;
    endsequence
    sequence pin_held;
        !rst_pin_i [*5];
    endsequence

    pready_timing_a: assert property (psel && !penable |=> pready_q)
        else $error("pready missing after setup");
    pready_access_a: assert property (pready_q |-> psel && penable)
        else $error("pready outside access phase");
    slverr_map_a: assert property (pready_q |->
        pslverr_q == (paddr != 12'h3bc && paddr != 12'h3fc))
        else $error("pslverr does not match address map");
    flags_onehot_a: assert property (pready_q && !pwrite && paddr == 12'h3bc |->
        $onehot0(prdata_q))
        else $error("cause flags not one-hot");
    sw_force_a: assert property (flag_wr ##0 (pwdata[4] && !pwdata[0] && sys_reset_n_q) |=>
        !sys_reset_n_q && rst_pin_oe_n_q)
        else $error("software reset wrong");
    por_force_a: assert property (flag_wr ##0 (pwdata[0] && sys_reset_n_q) |->
        ##[1:2] !rst_pin_oe_n_q)
        else $error("forced power reset does not drive pin");
    pin_reset_a: assert property (pin_held |-> !sys_reset_n_q)
        else $error("pin low without system reset");
    por_delay_a: assert property ($rose(rst_pin_oe_n_q) |->
        lo_q >= POR_DELAY_CYCLES - 24'h000001)
        else $error("pin released too early");
    release_hold_a: assert property ($rose(sys_reset_n_q) |-> hi_q >= 6'h0c && rst_pin_oe_n_q)
        else $error("system reset released too early");
    pin_od_a: assert property (rst_pin_o_q == 1'b0)
        else $error("pin data not low");
endmodule // rst_ctrl_checker

bind reset_source_and_watchdog_control rst_ctrl_checker #(
    .POR_DELAY_CYCLES(POR_DELAY_CYCLES)
) chk_u (.*);
`default_nettype wire

// ===== sim/reset_source_and_watchdog_control_tb_top.sv
/* Bench for the reset-source and watchdog block: APB tasks, queued reads.
   Assumes the design and its bound checker are compiled before it. */
`timescale 1ns/1ns
`default_nettype none
module reset_source_and_watchdog_control_tb_top;
    localparam [11:0] FLAGS = 12'h3bc;
    localparam [11:0] WDOG  = 12'h3fc;
    logic        clk = 1'b0, reset_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata_q;
    logic        pready_q, pslverr_q, rst_pin_o_q, rst_pin_oe_n_q, sys_reset_n_q;
    logic        pin_ext = 1'b1, cnv_n = 1'b1, cmp_n = 1'b1, sup = 1'b1;
    logic        alive = 1'b0, alive_en = 1'b1, mon = 1'b1;
    logic [32:0] exp_q[$];
    logic [2:0]  iv;
    integer      seed = 57482;
    int          bad_count = 0, n_checks = 0, n;
    wire         rst_pin_i = rst_pin_oe_n_q ? pin_ext : 1'b0;

    reset_source_and_watchdog_control #(
        .MCD_TIMEOUT_CYCLES(20'h0001e),
        .POR_DELAY_CYCLES  (24'h000028)
    ) dut_u (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
        .pready_q(pready_q), .pslverr_q(pslverr_q), .rst_pin_i(rst_pin_i),
        .rst_pin_o_q(rst_pin_o_q), .rst_pin_oe_n_q(rst_pin_oe_n_q),
        .convert_start_input(cnv_n), .comparator_out(cmp_n), .supply_ok(sup),
        .supply_monitor_enable_pin(mon), .sysclk_alive(alive),
        .sys_reset_n_q(sys_reset_n_q)
    );

    always #5 clk = ~clk;
    always @(posedge clk)
        if (alive_en)
            alive <= ~alive;
    // Read results against the oldest note
    always @(posedge clk)
        if (psel && penable && pready_q === 1'b1 && !pwrite)
            chk("apb read", exp_q.pop_front(), {pslverr_q, prdata_q});

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [32:0] e, input logic [32:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic give_up(input string what);
        bad_count++;
        $display("CHECK FAILED %s expected done seen timeout", what);
        close_out();
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                        input logic hold);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready_q !== 1'b1 && k < 16);
        if (pready_q !== 1'b1)
            give_up("pready");
        penable <= 1'b0;
        if (!hold) begin
            psel <= 1'b0;
            @(posedge clk);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        xfer(1'b0, a, 8'h00, 1'b0);
    endtask
    task automatic wait_sys(input logic v, output int c);
        c = 0;
        while (sys_reset_n_q !== v && c < 400) begin
            @(posedge clk);
            c++;
        end
        if (sys_reset_n_q !== v)
            give_up("system reset");
    endtask
    task automatic recover(input logic [7:0] fl);
        wait_sys(1'b0, n);
        pin_ext <= 1'b1;
        cnv_n <= 1'b1;
        cmp_n <= 1'b1;
        sup <= 1'b1;
        alive_en <= 1'b1;
        wait_sys(1'b1, n);
        rd(FLAGS, {25'h0, fl});
    endtask

    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        wait_sys(1'b1, n);
        rd(FLAGS, 33'h002);
        rd(WDOG, 33'h017);
        rd(12'h100, 33'h100000000);
        $display("test power up done");
        repeat (3) begin
            iv = 3'h4 | 3'($random(seed));
            wr(WDOG, 8'ha5);
            wr(WDOG, {5'h00, iv});
            rd(WDOG, 33'h010 | iv);
        end
        wr(WDOG, 8'ha5);
        xfer(1'b1, WDOG, 8'hde, 1'b1);
        wr(WDOG, 8'had);
        rd(WDOG, 33'h000 | iv);
        wr(WDOG, 8'ha5);
        rd(WDOG, 33'h010 | iv);
        xfer(1'b1, WDOG, 8'hde, 1'b1);
        xfer(1'b1, WDOG, 8'h03, 1'b1);
        wr(WDOG, 8'had);
        rd(WDOG, 33'h013);
        wr(WDOG, 8'hff);
        xfer(1'b1, WDOG, 8'hde, 1'b1);
        wr(WDOG, 8'had);
        rd(WDOG, 33'h013);
        $display("test watchdog control done");
        wr(WDOG, 8'ha5);
        wr(WDOG, 8'h00);
        wr(WDOG, 8'ha5);
        wait_sys(1'b0, n);
        chk("timeout cycles", 33'h1, {32'h0, n >= 60 && n <= 68});
        recover(8'h08);
        rd(WDOG, 33'h017);
        xfer(1'b1, WDOG, 8'hde, 1'b1);
        wr(WDOG, 8'had);
        rd(WDOG, 33'h007);
        $display("test watchdog timeout done");
        wr(FLAGS, 8'h12);
        recover(8'h10);
        wr(FLAGS, 8'h0a);
        rd(FLAGS, 33'h010);
        wr(FLAGS, 8'h00);
        cnv_n <= 1'b0;
        sup <= 1'b0;
        repeat (10) @(posedge clk);
        chk("no reset", 33'h1, {32'h0, sys_reset_n_q});
        cnv_n <= 1'b1;
        sup <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 2; i++) begin
            wr(FLAGS, i ? 8'h22 : 8'h42);
            if (i)
                cmp_n <= 1'b0;
            else
                cnv_n <= 1'b0;
            recover(i ? 8'h20 : 8'h40);
        end
        wr(FLAGS, 8'h06);
        alive_en <= 1'b0;
        recover(8'h04);
        pin_ext <= 1'b0;
        repeat (6) @(posedge clk);
        recover(8'h01);
        mon <= 1'b0;
        repeat (3) @(posedge clk);
        wr(FLAGS, 8'h00);
        mon <= 1'b1;
        sup <= 1'b0;
        recover(8'h02);
        wr(FLAGS, 8'h01);
        recover(8'h02);
        $display("test reset causes done");
        close_out();
    end
endmodule // reset_source_and_watchdog_control_tb_top
`default_nettype wire
